// ===== hdl/see_device.sv
`timescale 1ns/1ps
module see_device #(
  parameter int WR_CYCLES_P = see_pkg::WR_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Straps and protection pins
  input wire logic select_pin_high,
  input wire logic select_pin_mid,
  input wire logic select_pin_low,
  input wire logic write_protect,
  // Status
  output logic standby,
  output logic write_busy,
  // Link
  see_link_if.device link
);
  import see_pkg::*;

  localparam int SY_SCL = 0;
  localparam int SY_SDA = 1;
  localparam int SY_SEL_LO = 2;
  localparam int SY_SEL_HI = 4;
  localparam int SY_WP = 5;
  localparam int SY_W = 6;

  logic [SY_W-1:0] sync1_reg, sync2_reg;
  logic scl_d_reg, sda_d_reg;
  logic scl_s, sda_s, wp_s;
  logic [2:0] sel_s;
  logic scl_rise, scl_fall, start_cond, stop_cond;
  see_dev_state_type state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  logic ack_ph_reg, ack_ph_next;
  logic [DATA_W-1:0] shift_reg, shift_next, tx_reg, tx_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic rd_reg, rd_next, mack_reg, mack_next, wrote_reg, wrote_next;
  logic oe_n_reg, oe_n_next;
  logic [TIMER_W-1:0] timer_reg, timer_next;
  logic standby_reg, busy_reg, sda_out_reg;
  logic [DATA_W-1:0] mem_q [2**ADDR_W];
  logic [DATA_W-1:0] rd_byte;
  logic fifo_push, fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [FIFO_W-1:0] fifo_out_data;
  logic [ADDR_W-1:0] page_next_addr;

  // Everything from the pins passes two flops before use
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= 6'h03;
      sync2_reg <= 6'h03;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      sync1_reg <= {write_protect, select_pin_high, select_pin_mid, select_pin_low,
                    link.sda, link.scl};
      sync2_reg <= sync1_reg;
      scl_d_reg <= sync2_reg[SY_SCL];
      sda_d_reg <= sync2_reg[SY_SDA];
    end
  end

  // Bus events from the synchronised levels
  assign scl_s = sync2_reg[SY_SCL];
  assign sda_s = sync2_reg[SY_SDA];
  assign wp_s = sync2_reg[SY_WP];
  assign sel_s = sync2_reg[SY_SEL_HI:SY_SEL_LO];
  assign scl_rise = scl_s && !scl_d_reg;
  assign scl_fall = !scl_s && scl_d_reg;
  assign start_cond = scl_s && scl_d_reg && sda_d_reg && !sda_s;
  assign stop_cond = scl_s && scl_d_reg && !sda_d_reg && sda_s;

  // Counter plus one inside the current page only
  assign page_next_addr = {addr_reg[ADDR_W-1:PAGE_BITS],
                           addr_reg[PAGE_BITS-1:0] + PAGE_STEP};
  assign rd_byte = mem_q[addr_reg];
  assign fifo_out_ready = state_reg == DS_BUSY;

  // Protocol engine
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    ack_ph_next = ack_ph_reg;
    shift_next = shift_reg;
    tx_next = tx_reg;
    addr_next = addr_reg;
    rd_next = rd_reg;
    mack_next = mack_reg;
    wrote_next = wrote_reg;
    oe_n_next = oe_n_reg;
    timer_next = timer_reg;
    fifo_push = 1'b0;
    if (state_reg == DS_BUSY) begin
      // Deaf to the bus until the timed cycle and the drain are both done
      timer_next = timer_reg + 1'b1;
      if (timer_reg >= TIMER_W'(WR_CYCLES_P - 1) && !fifo_out_valid) begin
        state_next = DS_IDLE;
        timer_next = '0;
      end
    end else if (start_cond) begin
      // A start outside DS_BUSY restarts address reception, also mid-byte
      state_next = DS_DEV_ADDR;
      cnt_next = '0;
      ack_ph_next = 1'b0;
      oe_n_next = 1'b1;
    end else if (stop_cond) begin
      ack_ph_next = 1'b0;
      oe_n_next = 1'b1;
      wrote_next = 1'b0;
      state_next = wrote_reg ? DS_BUSY : DS_IDLE;
    end else if (state_reg != DS_IDLE) begin
      if (scl_rise) begin
        if (!ack_ph_reg) begin
          shift_next = {shift_reg[DATA_W-2:0], sda_s};
          cnt_next = cnt_reg + BIT_STEP;
        end else begin
          mack_next = !sda_s;
        end
      end else if (scl_fall) begin
        if (state_reg == DS_RD_DATA) begin
          if (!ack_ph_reg) begin
            if (cnt_reg == BITS_PER_WORD) begin
              oe_n_next = 1'b1;
              ack_ph_next = 1'b1;
            end else begin
              // Open drain: a one is sent by letting go of the line
              oe_n_next = tx_reg[DATA_W-2];
              tx_next = {tx_reg[DATA_W-2:0], 1'b1};
            end
          end else begin
            ack_ph_next = 1'b0;
            cnt_next = '0;
            if (mack_reg) begin
              tx_next = rd_byte;
              oe_n_next = rd_byte[DATA_W-1];
              addr_next = addr_reg + ADDR_STEP;
            end else begin
              oe_n_next = 1'b1;
              state_next = DS_IDLE;
            end
          end
        end else if (!ack_ph_reg && cnt_reg == BITS_PER_WORD) begin
          ack_ph_next = 1'b1;
          case (state_reg)
            DS_DEV_ADDR: begin
              if (shift_reg[DATA_W-1:DATA_W-4] == DEV_TYPE_CODE
                  && shift_reg[3:1] == sel_s) begin
                oe_n_next = 1'b0;
                rd_next = shift_reg[0];
              end else begin
                ack_ph_next = 1'b0;
                state_next = DS_IDLE;
              end
            end
            DS_WORD_ADDR: begin
              oe_n_next = 1'b0;
              addr_next = shift_reg;
            end
            default: begin
              if (wp_s) begin
                // Acknowledged but never queued, so the array stays intact
                oe_n_next = 1'b0;
                addr_next = page_next_addr;
              end else if (fifo_in_ready) begin
                fifo_push = 1'b1;
                oe_n_next = 1'b0;
                addr_next = page_next_addr;
                wrote_next = 1'b1;
              end else begin
                // Queue full: refuse the byte and drop off the bus
                ack_ph_next = 1'b0;
                state_next = DS_IDLE;
              end
            end
          endcase
        end else if (ack_ph_reg) begin
          ack_ph_next = 1'b0;
          cnt_next = '0;
          oe_n_next = 1'b1;
          case (state_reg)
            DS_DEV_ADDR: begin
              if (rd_reg) begin
                state_next = DS_RD_DATA;
                tx_next = rd_byte;
                oe_n_next = rd_byte[DATA_W-1];
                addr_next = addr_reg + ADDR_STEP;
              end else begin
                state_next = DS_WORD_ADDR;
              end
            end
            default: state_next = DS_WR_DATA;
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= DS_IDLE;
      cnt_reg <= '0;
      ack_ph_reg <= 1'b0;
      shift_reg <= '0;
      tx_reg <= '0;
      addr_reg <= '0;
      rd_reg <= 1'b0;
      mack_reg <= 1'b0;
      wrote_reg <= 1'b0;
      oe_n_reg <= 1'b1;
      timer_reg <= '0;
      standby_reg <= 1'b1;
      busy_reg <= 1'b0;
      sda_out_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      ack_ph_reg <= ack_ph_next;
      shift_reg <= shift_next;
      tx_reg <= tx_next;
      addr_reg <= addr_next;
      rd_reg <= rd_next;
      mack_reg <= mack_next;
      wrote_reg <= wrote_next;
      oe_n_reg <= oe_n_next;
      timer_reg <= timer_next;
      standby_reg <= state_next == DS_IDLE;
      busy_reg <= state_next == DS_BUSY;
      sda_out_reg <= 1'b0;
    end
  end

  // Queued bytes land in the array only during the timed cycle
  always_ff @(posedge clk) begin
    if (fifo_out_valid && fifo_out_ready) begin
      mem_q[fifo_out_data[FIFO_W-1:DATA_W]] <= fifo_out_data[DATA_W-1:0];
    end
  end

  // Write queue between the bus side and the array
  see_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_queue (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data({addr_reg, shift_reg}),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  assign link.sda_dev_out = sda_out_reg;
  assign link.sda_dev_oe_n = oe_n_reg;
  assign standby = standby_reg;
  assign write_busy = busy_reg;
endmodule

// ===== hdl/see_pkg.sv
package see_pkg;
  // Clock and timing
  localparam int CLK_FREQ_HZ = 25_000_000;
  localparam int SELF_TIMED_PROGRAM_TIME_MS = 5;
  localparam int MS_PER_S = 1000;
  // Longest time, so it rounds down
  localparam int WR_CYCLES = SELF_TIMED_PROGRAM_TIME_MS * (CLK_FREQ_HZ / MS_PER_S);
  localparam int TIMER_W = 20;
  localparam int SCL_QUARTER_CYCLES = 10;
  localparam int DIV_W = 4;
  // Array and words
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int PAGE_BITS = 3;
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_W = ADDR_W + DATA_W;
  localparam logic [3:0] DEV_TYPE_CODE = 4'ha;
  localparam logic [3:0] BITS_PER_WORD = 4'h8;
  localparam logic [3:0] BIT_STEP = 4'h1;
  localparam logic [PAGE_BITS-1:0] PAGE_STEP = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_STEP = 8'h01;
  localparam logic [1:0] PH_STEP = 2'h1;
  // States and commands
  typedef enum logic [2:0] {
    DS_IDLE, DS_DEV_ADDR, DS_WORD_ADDR, DS_WR_DATA, DS_RD_DATA, DS_BUSY
  } see_dev_state_type;
  typedef enum logic [1:0] {MS_IDLE, MS_START, MS_BIT, MS_STOP} see_mst_state_type;
  typedef enum logic [1:0] {CMD_START, CMD_STOP, CMD_WRITE, CMD_READ} see_cmd_type;
endpackage

// ===== hdl/see_link_if.sv
`timescale 1ns/1ps
// Two-wire link; the wired-AND of both open-drain data drivers is resolved here
interface see_link_if;
  logic scl;
  logic sda;
  logic sda_dev_out;
  logic sda_dev_oe_n;
  logic sda_mst_out;
  logic sda_mst_oe_n;
  // Pull-up wins unless some enable is low
  assign sda = (sda_dev_oe_n ? 1'b1 : sda_dev_out) & (sda_mst_oe_n ? 1'b1 : sda_mst_out);
  modport device (input scl, input sda, output sda_dev_out, output sda_dev_oe_n);
  modport master (output scl, input sda, output sda_mst_out, output sda_mst_oe_n);
endinterface

// ===== hdl/see_fifo.sv
`timescale 1ns/1ps
module see_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] PTR_STEP = AW'(1);
  localparam logic [AW:0] CNT_STEP = (AW+1)'(1);
  logic [WIDTH-1:0] store_q [DEPTH];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic push, pop;

  // Honest flags straight from the count
  assign in_ready = cnt_reg != FULL_COUNT;
  assign out_valid = cnt_reg != '0;
  assign out_data = store_q[rd_reg];

  // Pointer and count update
  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wr_next = push ? wr_reg + PTR_STEP : wr_reg;
    rd_next = pop ? rd_reg + PTR_STEP : rd_reg;
    cnt_next = cnt_reg;
    if (push && !pop) begin
      cnt_next = cnt_reg + CNT_STEP;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - CNT_STEP;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  // Storage needs no reset
  always_ff @(posedge clk) begin
    if (push) begin
      store_q[wr_reg] <= in_data;
    end
  end
endmodule

// ===== hdl/see_master.sv
`timescale 1ns/1ps
module see_master (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire see_pkg::see_cmd_type cmd_op,
  input wire logic [see_pkg::DATA_W-1:0] cmd_data,
  input wire logic cmd_ack,
  // Response
  output logic rsp_valid,
  output logic [see_pkg::DATA_W-1:0] rsp_data,
  output logic rsp_nack,
  // Link
  see_link_if.master link
);
  import see_pkg::*;

  logic [DIV_W-1:0] div_reg, div_next;
  logic tick;
  logic sda_s1_reg, sda_s2_reg;
  see_mst_state_type state_reg, state_next;
  see_cmd_type op_reg, op_next;
  logic [1:0] ph_reg, ph_next;
  logic [3:0] bit_reg, bit_next;
  logic [DATA_W-1:0] tx_reg, tx_next, rx_reg, rx_next;
  logic ack_req_reg, ack_req_next, nack_reg, nack_next;
  logic scl_reg, scl_next, oe_n_reg, oe_n_next;
  logic ready_reg, ready_next, rsp_valid_reg, rsp_valid_next;

  // Quarter-bit enable divided from the system clock
  assign tick = div_reg == DIV_W'(SCL_QUARTER_CYCLES - 1);
  assign div_next = tick ? '0 : div_reg + 1'b1;

  // Bit sequencer: four quarters per start, stop or data bit
  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    ph_next = ph_reg;
    bit_next = bit_reg;
    tx_next = tx_reg;
    rx_next = rx_reg;
    ack_req_next = ack_req_reg;
    nack_next = nack_reg;
    scl_next = scl_reg;
    oe_n_next = oe_n_reg;
    ready_next = ready_reg;
    rsp_valid_next = 1'b0;
    case (state_reg)
      MS_IDLE: begin
        if (cmd_valid && ready_reg) begin
          ready_next = 1'b0;
          op_next = cmd_op;
          tx_next = cmd_data;
          ack_req_next = cmd_ack;
          ph_next = '0;
          bit_next = '0;
          nack_next = 1'b0;
          case (cmd_op)
            CMD_START: state_next = MS_START;
            CMD_STOP: state_next = MS_STOP;
            default: state_next = MS_BIT;
          endcase
        end
      end
      MS_START: begin
        if (tick) begin
          ph_next = ph_reg + PH_STEP;
          case (ph_reg)
            2'h0: oe_n_next = 1'b1; // Release data; clock is low only on a repeated start
            2'h1: scl_next = 1'b1;
            2'h2: oe_n_next = 1'b0;
            default: begin
              scl_next = 1'b0;
              state_next = MS_IDLE;
              ready_next = 1'b1;
              rsp_valid_next = 1'b1;
            end
          endcase
        end
      end
      MS_STOP: begin
        if (tick) begin
          ph_next = ph_reg + PH_STEP;
          case (ph_reg)
            2'h0: oe_n_next = 1'b0;
            2'h1: scl_next = 1'b1;
            2'h2: oe_n_next = 1'b1;
            default: begin
              state_next = MS_IDLE;
              ready_next = 1'b1;
              rsp_valid_next = 1'b1;
            end
          endcase
        end
      end
      default: begin
        if (tick) begin
          ph_next = ph_reg + PH_STEP;
          case (ph_reg)
            2'h0: begin
              // Data is set up a full quarter before the clock rises
              if (bit_reg == BITS_PER_WORD) begin
                oe_n_next = (op_reg == CMD_READ) ? !ack_req_reg : 1'b1;
              end else begin
                oe_n_next = (op_reg == CMD_WRITE) ? tx_reg[DATA_W-1] : 1'b1;
              end
            end
            2'h1: scl_next = 1'b1;
            2'h2: begin
              if (bit_reg == BITS_PER_WORD) begin
                nack_next = sda_s2_reg;
              end else begin
                rx_next = {rx_reg[DATA_W-2:0], sda_s2_reg};
              end
            end
            default: begin
              scl_next = 1'b0;
              tx_next = {tx_reg[DATA_W-2:0], 1'b1};
              if (bit_reg == BITS_PER_WORD) begin
                oe_n_next = 1'b1;
                state_next = MS_IDLE;
                ready_next = 1'b1;
                rsp_valid_next = 1'b1;
              end else begin
                bit_next = bit_reg + BIT_STEP;
              end
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= '0;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      state_reg <= MS_IDLE;
      op_reg <= CMD_START;
      ph_reg <= '0;
      bit_reg <= '0;
      tx_reg <= '0;
      rx_reg <= '0;
      ack_req_reg <= 1'b0;
      nack_reg <= 1'b0;
      scl_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      ready_reg <= 1'b1;
      rsp_valid_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      sda_s1_reg <= link.sda;
      sda_s2_reg <= sda_s1_reg;
      state_reg <= state_next;
      op_reg <= op_next;
      ph_reg <= ph_next;
      bit_reg <= bit_next;
      tx_reg <= tx_next;
      rx_reg <= rx_next;
      ack_req_reg <= ack_req_next;
      nack_reg <= nack_next;
      scl_reg <= scl_next;
      oe_n_reg <= oe_n_next;
      ready_reg <= ready_next;
      rsp_valid_reg <= rsp_valid_next;
    end
  end

  assign link.scl = scl_reg;
  assign link.sda_mst_out = 1'b0;
  assign link.sda_mst_oe_n = oe_n_reg;
  assign cmd_ready = ready_reg;
  assign rsp_valid = rsp_valid_reg;
  assign rsp_data = rx_reg;
  assign rsp_nack = nack_reg;
endmodule

// ===== dv/see_link_properties.sv
`timescale 1ns/1ps
module see_link_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Link wires
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_dev_out,
  input wire logic sda_dev_oe_n,
  input wire logic sda_mst_out,
  input wire logic sda_mst_oe_n
);
  logic scl_q_reg, scl_q_next, sda_q_reg, sda_q_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] sh_reg, sh_next;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Count clock rises since the last start and shift in the line; saturates so long reads stay quiet
  always_comb begin
    scl_q_next = scl;
    sda_q_next = sda;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    if (scl && scl_q_reg && sda_q_reg && !sda) begin
      cnt_next = 4'h0;
    end else if (scl && !scl_q_reg) begin
      sh_next = {sh_reg[6:0], sda};
      if (cnt_reg != 4'hf) cnt_next = cnt_reg + 4'h1;
    end
  end

  // Register the helper state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
      cnt_reg <= 4'hf;
      sh_reg <= 8'h00;
    end else begin
      scl_q_reg <= scl_q_next;
      sda_q_reg <= sda_q_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
    end
  end

  a_dev_pulls_low: assert property (!sda_dev_oe_n |-> !sda_dev_out)
    else $error("device drives a high level");
  a_mst_pulls_low: assert property (!sda_mst_oe_n |-> !sda_mst_out)
    else $error("master drives a high level");
  a_dev_change_low: assert property ($changed(sda_dev_oe_n) |-> !scl && !$past(scl))
    else $error("device changed data while clock high");
  a_start_then_clock: assert property ($fell(sda) && scl |-> scl[*8] ##[1:4] !scl)
    else $error("start not followed by clock fall");
  a_stop_bus_idle: assert property ($rose(sda) && scl |-> (scl && sda)[*8])
    else $error("bus not idle after stop");
  a_addr_dev_quiet: assert property ($rose(scl) && cnt_reg < 4'h8 |-> sda_dev_oe_n)
    else $error("device drove during address word");
  a_bad_type_nack: assert property (
    $rose(scl) && cnt_reg == 4'h8 && sh_reg[7:4] != 4'ha |-> sda_dev_oe_n)
    else $error("device acked wrong type code");
  a_ack_stands: assert property ($fell(sda_dev_oe_n) |-> !sda_dev_oe_n[*8])
    else $error("device low drive too short");
  a_dev_releases: assert property (!sda_dev_oe_n |-> ##[1:400] sda_dev_oe_n)
    else $error("device holds line low too long");
endmodule

// ===== dv/serial_eeprom_two_wire_slave_tb.sv
`timescale 1ns/1ps
module serial_eeprom_two_wire_slave_tb;
  import see_pkg::*;
  logic clk, rst_n, wp, cmd_valid, cmd_ack, cmd_ready, rsp_valid, rsp_nack, standby, write_busy;
  logic [2:0] sel;
  logic [7:0] cmd_data, rsp_data, aw, ar;
  see_cmd_type cmd_op;
  logic [7:0] mem_exp [256];
  int fail_count = 0;
  int compares = 0;

  // Address words for our strap setting
  assign aw = {DEV_TYPE_CODE, sel, 1'b0};
  assign ar = {DEV_TYPE_CODE, sel, 1'b1};

  see_link_if link ();
  see_device #(.WR_CYCLES_P(1000)) i_see_device (.clk(clk), .rst_n(rst_n),
    .select_pin_high(sel[2]), .select_pin_mid(sel[1]), .select_pin_low(sel[0]),
    .write_protect(wp), .standby(standby), .write_busy(write_busy), .link(link));
  see_master i_see_master (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_ack(cmd_ack),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack), .link(link));
  see_link_properties i_see_link_properties (.clk(clk), .rst_n(rst_n), .scl(link.scl),
    .sda(link.sda), .sda_dev_out(link.sda_dev_out), .sda_dev_oe_n(link.sda_dev_oe_n),
    .sda_mst_out(link.sda_mst_out), .sda_mst_oe_n(link.sda_mst_oe_n));

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic test_done;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One master command; ready is high when idle so the take edge is the next one
  task automatic cmd(input see_cmd_type op, input logic [7:0] d, input logic a);
    int n;
    @(posedge clk);
    #1;
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_data = d;
    cmd_ack = a;
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 600) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 600) begin
      fail_count++;
      test_done();
    end
  endtask

  task automatic w(input logic [7:0] d, input logic nack);
    cmd(CMD_WRITE, d, 1'b0);
    chk("nack", {7'h0, nack}, {7'h0, rsp_nack});
  endtask

  // Acknowledge polling; busy says whether the first poll must be refused
  task automatic poll(input logic busy);
    int k;
    k = 0;
    do begin
      cmd(CMD_START, 8'h00, 1'b0);
      cmd(CMD_WRITE, aw, 1'b0);
      k++;
    end while (rsp_nack !== 1'b0 && k < 20);
    chk("poll_refused", {7'h0, busy}, {7'h0, (k > 1)});
    chk("poll_ack", 8'h00, {7'h0, rsp_nack});
    cmd(CMD_STOP, 8'h00, 1'b0);
    chk("write_busy_end", 8'h00, {7'h0, write_busy});
  endtask

  // Write n bytes from word address a; bytes past the queue depth must be refused
  task automatic wr(input logic [7:0] a, input int n, input logic [7:0] base);
    int i;
    cmd(CMD_START, 8'h00, 1'b0);
    w(aw, 1'b0);
    w(a, 1'b0);
    for (i = 0; i < n; i++) begin
      w(base + 8'(i), (i >= FIFO_DEPTH));
      if (i < FIFO_DEPTH && !wp) mem_exp[{a[7:3], 3'(a[2:0] + i)}] = base + 8'(i);
    end
    cmd(CMD_STOP, 8'h00, 1'b0);
    chk("write_busy_on", {7'h0, !wp}, {7'h0, write_busy});
    poll(!wp);
  endtask

  // Random read of n bytes, acking all but the last
  task automatic rd(input logic [7:0] a, input int n);
    int i;
    cmd(CMD_START, 8'h00, 1'b0);
    w(aw, 1'b0);
    w(a, 1'b0);
    cmd(CMD_START, 8'h00, 1'b0);
    w(ar, 1'b0);
    for (i = 0; i < n; i++) begin
      cmd(CMD_READ, 8'h00, (i < n - 1));
      chk("read_data", mem_exp[8'(a + i)], rsp_data);
    end
    cmd(CMD_STOP, 8'h00, 1'b0);
    chk("standby", 8'h01, {7'h0, standby});
  endtask

  // Every select code, then a wrong type code
  task automatic t_select;
    int s;
    for (s = 0; s < 8; s++) begin
      cmd(CMD_START, 8'h00, 1'b0);
      w({DEV_TYPE_CODE, 3'(s), 1'b0}, (3'(s) != sel));
    end
    cmd(CMD_START, 8'h00, 1'b0);
    w({4'hb, sel, 1'b0}, 1'b1);
    cmd(CMD_STOP, 8'h00, 1'b0);
    chk("standby_mismatch", 8'h01, {7'h0, standby});
  endtask

  // Read wrap at the top, then a current-address read from the counter
  task automatic t_wrap;
    wr(8'hff, 1, 8'h3c);
    wr(8'h00, 1, 8'hc3);
    rd(8'hff, 1);
    cmd(CMD_START, 8'h00, 1'b0);
    w(ar, 1'b0);
    cmd(CMD_READ, 8'h00, 1'b0);
    chk("current_read", mem_exp[0], rsp_data);
    cmd(CMD_STOP, 8'h00, 1'b0);
  endtask

  // Interrupted transfer, recovery sequence, then normal access
  task automatic t_recover;
    cmd(CMD_START, 8'h00, 1'b0);
    w(aw, 1'b0);
    cmd(CMD_START, 8'h00, 1'b0);
    w(8'hff, 1'b1);
    cmd(CMD_START, 8'h00, 1'b0);
    cmd(CMD_STOP, 8'h00, 1'b0);
    rd(8'h13, 1);
  endtask

  // Main sequence
  initial begin
    rst_n = 1'b0;
    sel = 3'h5;
    wp = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = CMD_START;
    cmd_data = 8'h00;
    cmd_ack = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk("standby_reset", 8'h01, {7'h0, standby});
    chk("busy_reset", 8'h00, {7'h0, write_busy});
    wr(8'h13, 1, 8'h5a);
    rd(8'h13, 1);
    t_select();
    wr(8'h2e, FIFO_DEPTH + 1, 8'h80);
    rd(8'h28, 8);
    wp = 1'b1;
    wr(8'h13, 1, 8'ha5);
    wp = 1'b0;
    rd(8'h13, 1);
    t_wrap();
    t_recover();
    test_done();
  end
endmodule
